// ==== hw/cpu_config_msr_pkg.sv ====
// Package for the dual-core configuration register bank.
// Assumes a plain register port with one-cycle read latency.
package cpu_config_msr_pkg;

	// ************************************************************
	// Register indices (each register takes one 64-bit word)
	// ************************************************************
	localparam logic [7:0] MACHINE_CHECK_ADDRESS_IDX = 8'h00;
	localparam logic [7:0] MACHINE_CHECK_TYPE_IDX = 8'h01;
	localparam logic [7:0] WAIT_MONITOR_LINE_SIZE_IDX = 8'h06;
	localparam logic [7:0] CYCLE_COUNT_IDX = 8'h10;
	localparam logic [7:0] PLATFORM_IDENTIFIER_IDX = 8'h17;
	localparam logic [7:0] LOCAL_IRQ_CTRL_BASE_IDX = 8'h1B;
	localparam logic [7:0] HARD_POWERON_CONFIG_IDX = 8'h2A;

	// ************************************************************
	// Field positions
	// ************************************************************
	localparam int PLATFORM_LSB = 50;
	localparam int PLATFORM_MSB = 52;
	localparam int DATA_ERR_CHECK_BIT = 1;
	localparam int RESP_ERR_CHECK_BIT = 2;
	localparam int ADDR_ERR_DRIVE_BIT = 3;
	localparam int BUS_ERR_REQ_BIT = 4;
	localparam int BUS_ERR_INTERNAL_BIT = 6;
	localparam int BUS_INIT_DRIVE_BIT = 7;
	localparam int TRISTATE_BIT = 8;
	localparam int SELF_TEST_BIT = 9;
	localparam int ADDR_ERR_OBSERVE_BIT = 10;
	localparam int BUS_INIT_OBSERVE_BIT = 12;
	localparam int QUEUE_DEPTH_BIT = 13;
	localparam int RESET_VECTOR_BIT = 14;
	localparam int CLUSTER_LSB = 16;
	localparam int CLUSTER_MSB = 17;

	// Writable bits of the power-on configuration register
	localparam logic [63:0] POWERON_WRITE_MASK = 64'h0000_0000_0000_00DE;
	// Enables and straps that read zero on the single-core predecessor
	localparam logic [63:0] LEGACY_ZERO_MASK = 64'h0000_0000_0003_54DE;

	// ************************************************************
	// Reset values
	// ************************************************************
	localparam logic [63:0] POWERON_RESET = 64'h0000_0000_0000_0000;
	localparam logic [63:0] WORD_RESET = 64'h0000_0000_0000_0000;

	// Strapped configuration, captured after reset release
	typedef struct packed {
		logic legacyVariant;
		logic [2:0] platformId;
		logic tristateSel;
		logic selfTestSel;
		logic addrErrObserve;
		logic busInitObserve;
		logic queueDepthOne;
		logic resetVectorLow;
		logic [1:0] clusterId;
	} strap_t;

	// Enables that steer each core's bus error logic
	typedef struct packed {
		logic dataErrCheck;
		logic respErrCheck;
		logic addrErrDrive;
		logic busErrRequest;
		logic busErrInternal;
		logic busInitDrive;
	} bus_ctrl_t;

endpackage

// ==== hw/cpu_config_msr_bank.sv ====
// Configuration register bank shared by two cores.
// Each core has its own register port; straps are synchronous and
// stable while reset is held.
//
// Overview of operation
// - Per-core registers get one copy per core
// - Shared registers exist once for both cores
// - Platform field bits 52:50, rest reserved
// - Power-on config: writable enables, read-only configuration
// - Bit 1 enables data error checking
// - Bit 2 enables response checks, redundancy input
// - Bit 3 permits driving address error output
// - Bit 4 enables bus error on requests
// - Bit 6 enables bus error on internal errors
// - Bit 7 enables driving bus initialize output
// - Bit 8 reports output tri-state selection
// - Bit 9 reports self-test selection
// - Bit 10 reports address error observation
// - Bit 12 reports bus initialize observation
// - Bit 13 reports queue depth one/eight
// - Bit 14 selects reset vector location
// - Bits 17:16 cluster id, zero on legacy
// - Legacy variant reads error/vector bits zero
// - Bits 0, 5, 11, 15 reserved
//
// The implementer's own choice: strobed register access.
`timescale 1ns/10ps
`default_nettype none

module cpu_config_msr_bank #(
	parameter int NUM_CORES = 2
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] regAddr [NUM_CORES],
	input wire logic [63:0] regWriteData [NUM_CORES],
	input wire logic regWrite [NUM_CORES],
	input wire logic regRead [NUM_CORES],
	output logic [63:0] regReadData [NUM_CORES],
	input wire cpu_config_msr_pkg::strap_t strapIn,
	input wire logic [63:0] machineCheckAddrIn [NUM_CORES],
	input wire logic [63:0] machineCheckTypeIn [NUM_CORES],
	output cpu_config_msr_pkg::bus_ctrl_t busCtrl
);

	// Only one or two cores are served by the shared register logic
	if (NUM_CORES < 1 || NUM_CORES > 2) begin : gBadCores
		$error("NUM_CORES must be 1 or 2");
	end

	// ************************************************************
	// Strap capture
	// ************************************************************
	// Straps taken by a clocked process after release, never as reset
	logic strapTaken_reg;
	cpu_config_msr_pkg::strap_t strap_reg;

	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			strapTaken_reg <= 1'b0;
			strap_reg <= '0;
		end else if (!strapTaken_reg) begin
			strapTaken_reg <= 1'b1;
			strap_reg <= strapIn;
		end
	end

	// ************************************************************
	// Shared power-on configuration
	// ************************************************************
	logic [63:0] poweron_reg;
	logic [63:0] poweronView;
	logic [63:0] strapBits;
	logic [63:0] platformView;

	// Lower-numbered core wins if both write in the same cycle
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			poweron_reg <= cpu_config_msr_pkg::POWERON_RESET;
		end else begin
			for (int c = NUM_CORES - 1; c >= 0; c--) begin
				if (regWrite[c] && regAddr[c] ==
				    cpu_config_msr_pkg::HARD_POWERON_CONFIG_IDX) begin
					poweron_reg <= regWriteData[c] &
					    cpu_config_msr_pkg::POWERON_WRITE_MASK;
				end
			end
		end
	end

	always_comb begin
		strapBits = '0;
		strapBits[cpu_config_msr_pkg::TRISTATE_BIT] = strap_reg.tristateSel;
		strapBits[cpu_config_msr_pkg::SELF_TEST_BIT] = strap_reg.selfTestSel;
		strapBits[cpu_config_msr_pkg::ADDR_ERR_OBSERVE_BIT] =
		    strap_reg.addrErrObserve;
		strapBits[cpu_config_msr_pkg::BUS_INIT_OBSERVE_BIT] =
		    strap_reg.busInitObserve;
		strapBits[cpu_config_msr_pkg::QUEUE_DEPTH_BIT] =
		    strap_reg.queueDepthOne;
		strapBits[cpu_config_msr_pkg::RESET_VECTOR_BIT] =
		    strap_reg.resetVectorLow;
		strapBits[cpu_config_msr_pkg::CLUSTER_MSB:
		    cpu_config_msr_pkg::CLUSTER_LSB] = strap_reg.clusterId;
		// Reserved bits 0, 5, 11, 15 stay zero
		poweronView = poweron_reg | strapBits;
		if (strap_reg.legacyVariant)
			poweronView = poweronView &
			    ~cpu_config_msr_pkg::LEGACY_ZERO_MASK;
		platformView = '0;
		platformView[cpu_config_msr_pkg::PLATFORM_MSB:
		    cpu_config_msr_pkg::PLATFORM_LSB] = strap_reg.platformId;
	end

	// Enables seen by the bus logic; same gating as the read view
	always_ff @(posedge clk_sys or negedge reset_n) begin
		if (!reset_n) begin
			busCtrl <= '0;
		end else begin
			busCtrl.dataErrCheck <=
			    poweronView[cpu_config_msr_pkg::DATA_ERR_CHECK_BIT];
			busCtrl.respErrCheck <=
			    poweronView[cpu_config_msr_pkg::RESP_ERR_CHECK_BIT];
			busCtrl.addrErrDrive <=
			    poweronView[cpu_config_msr_pkg::ADDR_ERR_DRIVE_BIT];
			busCtrl.busErrRequest <=
			    poweronView[cpu_config_msr_pkg::BUS_ERR_REQ_BIT];
			busCtrl.busErrInternal <=
			    poweronView[cpu_config_msr_pkg::BUS_ERR_INTERNAL_BIT];
			busCtrl.busInitDrive <=
			    poweronView[cpu_config_msr_pkg::BUS_INIT_DRIVE_BIT];
		end
	end

	// ************************************************************
	// Per-core registers
	// ************************************************************
	genvar g;
	generate
		for (g = 0; g < NUM_CORES; g++) begin : gCore
			logic [63:0] lineSize_reg;
			logic [63:0] cycleCount_reg;
			logic [63:0] irqBase_reg;
			logic hit;

			assign hit = regWrite[g];

			// Each core's copy is touched only by its own port
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					lineSize_reg <= cpu_config_msr_pkg::WORD_RESET;
					irqBase_reg <= cpu_config_msr_pkg::WORD_RESET;
				end else if (hit) begin
					if (regAddr[g] ==
					    cpu_config_msr_pkg::WAIT_MONITOR_LINE_SIZE_IDX)
						lineSize_reg <= regWriteData[g];
					if (regAddr[g] ==
					    cpu_config_msr_pkg::LOCAL_IRQ_CTRL_BASE_IDX)
						irqBase_reg <= regWriteData[g];
				end
			end

			// Free-running; a write loads a new count
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n)
					cycleCount_reg <= cpu_config_msr_pkg::WORD_RESET;
				else if (hit && regAddr[g] ==
				    cpu_config_msr_pkg::CYCLE_COUNT_IDX)
					cycleCount_reg <= regWriteData[g];
				else
					cycleCount_reg <= cycleCount_reg + 64'h1;
			end

			// Read data only in the cycle after the strobe, else zero
			always_ff @(posedge clk_sys or negedge reset_n) begin
				if (!reset_n) begin
					regReadData[g] <= '0;
				end else if (!regRead[g]) begin
					regReadData[g] <= '0;
				end else begin
					case (regAddr[g])
					cpu_config_msr_pkg::MACHINE_CHECK_ADDRESS_IDX:
						regReadData[g] <= machineCheckAddrIn[g];
					cpu_config_msr_pkg::MACHINE_CHECK_TYPE_IDX:
						regReadData[g] <= machineCheckTypeIn[g];
					cpu_config_msr_pkg::WAIT_MONITOR_LINE_SIZE_IDX:
						regReadData[g] <= lineSize_reg;
					cpu_config_msr_pkg::CYCLE_COUNT_IDX:
						regReadData[g] <= cycleCount_reg;
					cpu_config_msr_pkg::PLATFORM_IDENTIFIER_IDX:
						regReadData[g] <= platformView;
					cpu_config_msr_pkg::LOCAL_IRQ_CTRL_BASE_IDX:
						regReadData[g] <= irqBase_reg;
					cpu_config_msr_pkg::HARD_POWERON_CONFIG_IDX:
						regReadData[g] <= poweronView;
					default:
						regReadData[g] <= '0;
					endcase
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// ==== sim/cpu_config_msr_bank_assertions.sv ====
// Port assertions for the configuration bank, bound into each instance.
// Straps are expected to change only while reset is low.
`timescale 1ns/10ps
`default_nettype none
module cpu_config_msr_bank_assertions #(
	parameter int NUM_CORES = 2
) (
	input wire logic clk_sys,
	input wire logic reset_n,
	input wire logic [7:0] regAddr [NUM_CORES],
	input wire logic [63:0] regWriteData [NUM_CORES],
	input wire logic regWrite [NUM_CORES],
	input wire logic regRead [NUM_CORES],
	input wire logic [63:0] regReadData [NUM_CORES],
	input wire cpu_config_msr_pkg::strap_t strapIn,
	input wire logic [63:0] machineCheckAddrIn [NUM_CORES],
	input wire cpu_config_msr_pkg::bus_ctrl_t busCtrl
);
	logic [7:0] wd1;
	logic [7:0] wd2;
	// Two stages to line up with the bus enable latency
	always_ff @(posedge clk_sys) begin
		wd1 <= regWriteData[0][7:0];
		wd2 <= wd1;
	end
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!reset_n);
	sequence cfgWrite;
		regWrite[0] && regAddr[0] == 8'h2A && !strapIn.legacyVariant;
	endsequence
	// First read after release would still see pre-capture straps
	sequence cfgRead;
		regRead[1] && regAddr[1] == 8'h2A && $past(reset_n);
	endsequence
	cfg_apply_a: assert property (cfgWrite |-> ##2 busCtrl ==
		{wd2[1], wd2[2], wd2[3], wd2[4], wd2[6], wd2[7]})
		else $error("bus enables differ from write");
	shared_write_a: assert property (cfgWrite ##1 cfgRead |=>
		regReadData[1][7:0] == (wd2 & 8'hDE)) else $error("shared readback wrong");
	legacy_force_a: assert property (strapIn.legacyVariant &&
		$past(strapIn.legacyVariant, 2) |-> busCtrl == 6'h00)
		else $error("legacy enables not zero");
	strap_ro_a: assert property (cfgRead |=> {regReadData[1][13],
		regReadData[1][9:8]} == {strapIn.queueDepthOne, strapIn.selfTestSel,
		strapIn.tristateSel}) else $error("strap bits read wrong");
	strap_gated_a: assert property (cfgRead |=>
		(regReadData[1][17:10] & 8'hF7) == (strapIn.legacyVariant ? 8'h00 :
		{strapIn.clusterId, 1'h0, strapIn.resetVectorLow, 1'h0,
		strapIn.busInitObserve, 1'h0, strapIn.addrErrObserve}))
		else $error("gated strap bits read wrong");
	reserved_zero_a: assert property (cfgRead |=> !regReadData[1][0] &&
		!regReadData[1][5]) else $error("reserved bit set");
	read_idle_a: assert property (!regRead[1] |=> regReadData[1] == 64'h0)
		else $error("read data outside read cycle");
	mc_read_a: assert property (regRead[1] && regAddr[1] == 8'h00 |=>
		regReadData[1] == $past(machineCheckAddrIn[1])) else $error("core data");
endmodule
bind cpu_config_msr_bank cpu_config_msr_bank_assertions #(.NUM_CORES(NUM_CORES))
	chk (.clk_sys(clk_sys), .reset_n(reset_n), .regAddr(regAddr),
	.regWriteData(regWriteData), .regWrite(regWrite), .regRead(regRead),
	.regReadData(regReadData), .strapIn(strapIn), .busCtrl(busCtrl),
	.machineCheckAddrIn(machineCheckAddrIn));
`default_nettype wire

// ==== sim/tb.sv ====
// Self-checking bench: both cores reach the bank through tasks.
// Assumes one-cycle read data and straps settled during reset.
`timescale 1ns/10ps
`default_nettype none
module tb;
	logic clk_sys = 1'h0;
	logic reset_n = 1'h0;
	logic regWrite [2] = '{1'h0, 1'h0};
	logic regRead [2] = '{1'h0, 1'h0};
	logic [7:0] regAddr [2] = '{8'h00, 8'h00};
	logic [63:0] regWriteData [2] = '{64'h0, 64'h0};
	logic [63:0] regReadData [2];
	logic [63:0] mc [2] = '{64'h0123_4567_89AB_CDEF, 64'hFEDC_BA98_7654_3210};
	logic [63:0] mcT [2] = '{64'h0F0F_0F0F_5555_AAAA, 64'hF0F0_F0F0_AAAA_5555};
	cpu_config_msr_pkg::strap_t strap;
	cpu_config_msr_pkg::bus_ctrl_t busCtrl;
	int nFail = 0;
	int nTests = 0;
	always #4 clk_sys = ~clk_sys;
	cpu_config_msr_bank #(.NUM_CORES(2)) DUT (.clk_sys(clk_sys),
		.reset_n(reset_n), .regAddr(regAddr), .regWriteData(regWriteData),
		.regWrite(regWrite), .regRead(regRead), .regReadData(regReadData),
		.strapIn(strap), .machineCheckAddrIn(mc), .machineCheckTypeIn(mcT),
		.busCtrl(busCtrl));
	task automatic check(input string name, input logic [63:0] seen, exp);
		nTests++;
		if (seen !== exp) begin
			nFail++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic wr(input int c, input logic [7:0] a, input logic [63:0] d);
		regWrite[c] <= 1'h1;
		regAddr[c] <= a;
		regWriteData[c] <= d;
		@(posedge clk_sys);
		regWrite[c] <= 1'h0;
	endtask
	task automatic rd(input int c, input logic [7:0] a, input logic [63:0] e);
		regRead[c] <= 1'h1;
		regAddr[c] <= a;
		@(posedge clk_sys);
		regRead[c] <= 1'h0;
		// Data stands until this edge; read before it is replaced
		@(posedge clk_sys);
		check($sformatf("read %h", a), regReadData[c], e);
	endtask
	function automatic logic [63:0] expCfg(input logic [63:0] w);
		logic [17:0] e;
		e = {strap.clusterId, 1'h0, strap.resetVectorLow, strap.queueDepthOne,
			strap.busInitObserve, 1'h0, strap.addrErrObserve, strap.selfTestSel,
			strap.tristateSel, w[7:0] & 8'hDE};
		// Legacy parts keep only tri-state, self-test and queue depth
		if (strap.legacyVariant) e = e & 18'h02300;
		return 64'(e);
	endfunction
	task automatic sweep;
		logic [63:0] w;
		for (int i = 0; i < 9; i++) begin
			w = (i == 8) ? 64'hFFFF_FFFF_FFFF_FFFF : 64'h1 << i;
			wr(0, 8'h2A, w);
			rd(1, 8'h2A, expCfg(w));
			check("busCtrl", 64'(busCtrl),
				strap.legacyVariant ? 64'h0 : 64'({w[1], w[2], w[3], w[4], w[6], w[7]}));
		end
	endtask
	task automatic restart(input cpu_config_msr_pkg::strap_t s);
		reset_n <= 1'h0;
		strap <= s;
		repeat (2) @(posedge clk_sys);
		reset_n <= 1'h1;
		repeat (2) @(posedge clk_sys);
	endtask
	task automatic print_verdict;
		if (nFail == 0 && nTests > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		logic [7:0] a;
		restart('{1'h0, 3'h5, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 2'h2});
		rd(0, 8'h2A, expCfg(64'h0));
		rd(1, 8'h17, 64'h0014_0000_0000_0000);
		wr(0, 8'h17, 64'hFFFF_FFFF_FFFF_FFFF);
		rd(0, 8'h17, 64'h0014_0000_0000_0000);
		sweep();
		for (int i = 0; i < 2; i++) begin
			a = i ? 8'h1B : 8'h06;
			wr(0, a, mc[0]);
			wr(1, a, mcT[1]);
			rd(0, a, mc[0]);
			rd(1, a, mcT[1]);
		end
		rd(0, 8'h00, mc[0]);
		rd(1, 8'h00, mc[1]);
		rd(1, 8'h01, mcT[1]);
		wr(0, 8'h10, 64'h0000_0000_0000_0005);
		rd(0, 8'h10, 64'h0000_0000_0000_0005);
		wr(1, 8'h3F, 64'hFFFF_FFFF_FFFF_FFFF);
		rd(1, 8'h3F, 64'h0);
		restart('{1'h1, 3'h2, 1'h0, 1'h1, 1'h0, 1'h1, 1'h0, 1'h1, 2'h1});
		sweep();
		print_verdict();
	end
endmodule
`default_nettype wire
